/* sfp_front.sv */
`timescale 1ns/1ps
`default_nettype none
module sfp_front
  import sfp_pkg::*;
#(
  parameter int unsigned PUW_US       = 10,
  parameter int unsigned PROG_CYCLES  = 400,
  parameter int unsigned ERASE_CYCLES = 2000,
  parameter int unsigned WRSR_CYCLES  = 800
) (
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  // Serial link
  input  wire logic       spi_clk_in,
  input  wire logic       sel_n_in,
  input  wire logic       write_guard_n_in,
  // Lane zero, single-lane serial_in_line
  input  wire logic       dual_lane_zero_in,
  output logic            dual_lane_zero_out,
  output logic            dual_lane_zero_oe_out,
  // Lane one, single-lane output
  input  wire logic       dual_lane_one_in,
  output logic            dual_lane_one_out,
  output logic            dual_lane_one_oe_out,
  // Status view
  output logic      [7:0] status_word_one_out
);

  localparam int unsigned PUW_CYCLES = PUW_US * CLK_MHZ;
  localparam logic [TMR_W-1:0] TMR_ONE = 24'h000001;

  logic [4:0] sync_w;
  logic       sclk_s;
  logic       sel_s;
  logic       lane0_s;
  logic       lane1_s;
  logic       guard_s;

  sfp_sync #(
    .W       (5),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .async_in   ({write_guard_n_in, dual_lane_one_in, dual_lane_zero_in, sel_n_in, spi_clk_in}),
    .sync_out   (sync_w)
  );

  assign {guard_s, lane1_s, lane0_s, sel_s, sclk_s} = sync_w;

  // Link state
  logic              sclk_prev_q, sclk_prev_d;
  logic              sel_prev_q,  sel_prev_d;
  logic [CNT_W-1:0]  bit_cnt_q,   bit_cnt_d;
  logic [7:0]        opcode_q,    opcode_d;
  logic [ADDR_W-1:0] addr_q,      addr_d;
  logic [7:0]        wr1_q,       wr1_d;
  logic [7:0]        wr2_q,       wr2_d;
  logic              l0_out_q,    l0_out_d;
  logic              l0_oe_q,     l0_oe_d;
  logic              l1_out_q,    l1_out_d;
  logic              l1_oe_q,     l1_oe_d;

  // Engine state
  sfp_eng_t          eng_q,       eng_d;
  logic [TMR_W-1:0]  cnt_q,       cnt_d;
  logic              write_enable_latch_q, write_enable_latch_d;
  sfp_prot_t         prot_q,      prot_d;
  logic              armed_q,     armed_d;
  logic [7:0]        status_q,    status_d;

  logic       rise;
  logic       fall;
  logic       frame_end;
  logic       busy;
  logic [7:0] sr1;
  logic [7:0] sr2;
  logic [1:0] lock;
  logic       lock_ok;

  function automatic logic [4:0] prot_log2(input sfp_prot_t p);
    logic [4:0] k;
    k = 5'h00;
    if (p.sec)
    begin
      k = SEC_BASE + 5'(p.bp);
      if (k > SEC_MAX)
        k = SEC_MAX;
    end
    else if (p.bp == BP_ALL)
      k = ALL_LOG2;
    else
      k = BLK_BASE + 5'(p.bp);
    return k;
  endfunction

  function automatic logic prot_hit(input sfp_prot_t p, input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] mask;
    logic              in_range;
    mask     = {ADDR_W{1'b1}} << prot_log2(p);
    in_range = p.tb ? ((a & mask) == '0) : ((a & mask) == mask);
    return ((p.bp != 3'h0) && in_range) ^ p.cmp;
  endfunction

  function automatic logic chip_hit(input sfp_prot_t p);
    return p.cmp ? !((p.bp != 3'h0) && (prot_log2(p) == ALL_LOG2)) : (p.bp != 3'h0);
  endfunction

  // Both idle clock levels work: only transitions inside a select count
  assign rise      = sclk_s & ~sclk_prev_q & ~sel_s;
  assign fall      = ~sclk_s & sclk_prev_q & ~sel_s;
  assign frame_end = sel_s & ~sel_prev_q;
  assign busy      = (eng_q == EN_BUSY) || (eng_q == EN_RESET);
  assign sr1       = {prot_q.lock_lo, prot_q.sec, prot_q.tb, prot_q.bp, write_enable_latch_q, busy};
  assign sr2       = {1'b0, prot_q.cmp, 5'h00, prot_q.lock_hi};
  assign lock      = {prot_q.lock_hi, prot_q.lock_lo};
  // Pin only matters in the pin-lock code; power and permanent codes always block
  assign lock_ok   = (lock == LOCK_OPEN) || ((lock == LOCK_PIN) && guard_s);

  always_comb
  begin
    sclk_prev_d = sclk_s;
    sel_prev_d  = sel_s;
    bit_cnt_d   = bit_cnt_q;
    opcode_d    = opcode_q;
    addr_d      = addr_q;
    wr1_d       = wr1_q;
    wr2_d       = wr2_q;
    l0_out_d    = l0_out_q;
    l0_oe_d     = l0_oe_q;
    l1_out_d    = l1_out_q;
    l1_oe_d     = l1_oe_q;
    if (sel_prev_q && !sel_s)
      bit_cnt_d = '0;
    if (rise)
    begin
      if (bit_cnt_q != {CNT_W{1'b1}})
        bit_cnt_d = bit_cnt_q + 7'h01;
      if (bit_cnt_q < OPC_BITS)
        opcode_d = {opcode_q[6:0], lane0_s};
      else if (opcode_q == OP_DIOR)
      begin
        if (bit_cnt_q < DIOR_ADDR)
          addr_d = {addr_q[ADDR_W-3:0], lane1_s, lane0_s};
      end
      else if (bit_cnt_q < ADDR_END)
        addr_d = {addr_q[ADDR_W-2:0], lane0_s};
      if ((bit_cnt_q >= OPC_BITS) && (bit_cnt_q < WRSR_ONE))
        wr1_d = {wr1_q[6:0], lane0_s};
      if ((bit_cnt_q >= WRSR_ONE) && (bit_cnt_q < WRSR_TWO))
        wr2_d = {wr2_q[6:0], lane0_s};
    end
    if (fall)
    begin
      l0_oe_d = 1'b0;
      l1_oe_d = 1'b0;
      if ((opcode_q == OP_RDSR1) && (bit_cnt_q >= OPC_BITS))
      begin
        l1_oe_d  = 1'b1;
        l1_out_d = sr1[~bit_cnt_q[2:0]];
      end
      else if ((opcode_q == OP_RDSR2) && (bit_cnt_q >= OPC_BITS))
      begin
        l1_oe_d  = 1'b1;
        l1_out_d = sr2[~bit_cnt_q[2:0]];
      end
      else if (!busy && (((opcode_q == OP_DOR) && (bit_cnt_q >= DOR_START))
               || ((opcode_q == OP_DIOR) && (bit_cnt_q >= DIOR_START))))
      begin
        l0_oe_d  = 1'b1;
        l1_oe_d  = 1'b1;
        l1_out_d = ERASED_BYTE[{~bit_cnt_q[1:0], 1'b1}];
        l0_out_d = ERASED_BYTE[{~bit_cnt_q[1:0], 1'b0}];
      end
    end
    if (sel_s)
    begin
      l0_oe_d = 1'b0;
      l1_oe_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sclk_prev_q <= 1'b0;
      sel_prev_q  <= 1'b1;
      bit_cnt_q   <= '0;
      opcode_q    <= 8'h00;
      addr_q      <= '0;
      wr1_q       <= 8'h00;
      wr2_q       <= 8'h00;
      l0_out_q    <= 1'b0;
      l0_oe_q     <= 1'b0;
      l1_out_q    <= 1'b0;
      l1_oe_q     <= 1'b0;
    end
    else
    begin
      sclk_prev_q <= sclk_prev_d;
      sel_prev_q  <= sel_prev_d;
      bit_cnt_q   <= bit_cnt_d;
      opcode_q    <= opcode_d;
      addr_q      <= addr_d;
      wr1_q       <= wr1_d;
      wr2_q       <= wr2_d;
      l0_out_q    <= l0_out_d;
      l0_oe_q     <= l0_oe_d;
      l1_out_q    <= l1_out_d;
      l1_oe_q     <= l1_oe_d;
    end
  end

  always_comb
  begin
    eng_d   = eng_q;
    cnt_d   = cnt_q;
    write_enable_latch_d = write_enable_latch_q;
    prot_d  = prot_q;
    armed_d = armed_q;
    case (eng_q)
      EN_HOLD, EN_BUSY, EN_RESET:
      begin
        if (cnt_q <= TMR_ONE)
          eng_d = EN_READY;
        else
          cnt_d = cnt_q - TMR_ONE;
      end
      EN_READY:
        eng_d = EN_READY;
      default:
        eng_d = EN_READY;
    endcase
    // A busy engine takes no instruction; status reads are still served by the link logic
    if (frame_end && !busy && (bit_cnt_q >= OPC_BITS))
    begin
      armed_d = (bit_cnt_q == OPC_BITS) && (opcode_q == OP_RSTEN);
      case (opcode_q)
        OP_WREN:
          if ((bit_cnt_q == OPC_BITS) && (eng_q != EN_HOLD))
            write_enable_latch_d = 1'b1;
        OP_WRDI:
          if (bit_cnt_q == OPC_BITS)
            write_enable_latch_d = 1'b0;
        OP_WRSR:
          if (((bit_cnt_q == WRSR_ONE) || (bit_cnt_q == WRSR_TWO)) && write_enable_latch_q && lock_ok)
          begin
            prot_d.lock_lo = wr1_q[7];
            prot_d.sec     = wr1_q[6];
            prot_d.tb      = wr1_q[5];
            prot_d.bp      = wr1_q[4:2];
            if (bit_cnt_q == WRSR_TWO)
            begin
              prot_d.lock_hi = wr2_q[SR2_LOCK_HI];
              prot_d.cmp     = wr2_q[SR2_CMP];
            end
            write_enable_latch_d = 1'b0;
            eng_d = EN_BUSY;
            cnt_d = TMR_W'(WRSR_CYCLES);
          end
        OP_PP:
          if ((bit_cnt_q >= PP_MIN) && write_enable_latch_q && !prot_hit(prot_q, addr_q))
          begin
            write_enable_latch_d = 1'b0;
            eng_d = EN_BUSY;
            cnt_d = TMR_W'(PROG_CYCLES);
          end
        OP_SE, OP_BE:
          if ((bit_cnt_q == ADDR_END) && write_enable_latch_q && !prot_hit(prot_q, addr_q))
          begin
            write_enable_latch_d = 1'b0;
            eng_d = EN_BUSY;
            cnt_d = TMR_W'(ERASE_CYCLES);
          end
        OP_CE1, OP_CE2:
          if ((bit_cnt_q == OPC_BITS) && write_enable_latch_q && !chip_hit(prot_q))
          begin
            write_enable_latch_d = 1'b0;
            eng_d = EN_BUSY;
            cnt_d = TMR_W'(ERASE_CYCLES);
          end
        OP_RST:
          if ((bit_cnt_q == OPC_BITS) && armed_q)
          begin
            write_enable_latch_d = 1'b0;
            eng_d = EN_RESET;
            cnt_d = TMR_W'(RST_CYCLES);
          end
        default:
          write_enable_latch_d = write_enable_latch_q;
      endcase
    end
    status_d = {sr1[7:2], write_enable_latch_d, (eng_d == EN_BUSY) || (eng_d == EN_RESET)};
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      eng_q    <= EN_HOLD;
      cnt_q    <= TMR_W'(PUW_CYCLES);
      write_enable_latch_q <= 1'b0;
      prot_q   <= PROT_RST;
      armed_q  <= 1'b0;
      status_q <= 8'h00;
    end
    else
    begin
      eng_q    <= eng_d;
      cnt_q    <= cnt_d;
      write_enable_latch_q <= write_enable_latch_d;
      prot_q   <= prot_d;
      armed_q  <= armed_d;
      status_q <= status_d;
    end
  end

  assign dual_lane_zero_out    = l0_out_q;
  assign dual_lane_zero_oe_out = l0_oe_q;
  assign dual_lane_one_out     = l1_out_q;
  assign dual_lane_one_oe_out  = l1_oe_q;
  assign status_word_one_out   = status_q;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  sequence wren_done;
    frame_end && (opcode_q == OP_WREN) && (bit_cnt_q == OPC_BITS) && (eng_q == EN_READY);
  endsequence

  sequence prog_go;
    frame_end && (eng_q == EN_READY) && write_enable_latch_q && (opcode_q == OP_PP)
      && (bit_cnt_q >= PP_MIN) && !prot_hit(prot_q, addr_q);
  endsequence

  sequence cycle_last;
    (eng_q == EN_BUSY) && (cnt_q == TMR_ONE);
  endsequence

  latch_set_a: assert property (wren_done |=> write_enable_latch_q ##1 status_q[SR_LATCH])
    else $error("write enable did not set the latch");
  latch_clear_a: assert property (frame_end && (eng_q == EN_READY) && (opcode_q == OP_WRDI)
      && (bit_cnt_q == OPC_BITS) |=> !write_enable_latch_q)
    else $error("write disable left the latch set");
  busy_start_a: assert property (prog_go
      |=> (eng_q == EN_BUSY) && !write_enable_latch_q ##1 status_q[SR_BUSY])
    else $error("program did not raise busy");
  busy_end_a: assert property (cycle_last |=> (eng_q == EN_READY) ##1 !status_q[SR_BUSY])
    else $error("busy did not clear at cycle end");
  busy_ignore_a: assert property ((eng_q == EN_BUSY) && (cnt_q > TMR_ONE)
      |=> $stable(write_enable_latch_q) && $stable(prot_q))
    else $error("instruction taken while busy");
  puw_block_a: assert property ((eng_q == EN_HOLD) |=> !write_enable_latch_q)
    else $error("latch set during power-up hold");
  rst_seq_a: assert property (frame_end && (eng_q == EN_READY) && (opcode_q == OP_RST) && !armed_q
      |=> (eng_q != EN_RESET))
    else $error("reset taken without reset enable");
  guard_lock_a: assert property (frame_end && (opcode_q == OP_WRSR) && (lock == LOCK_PIN) && !guard_s
      |=> $stable(prot_q))
    else $error("status write passed a low guard pin");
  prot_skip_a: assert property (frame_end && (eng_q == EN_READY) && (opcode_q == OP_SE)
      && prot_hit(prot_q, addr_q) |=> (eng_q == EN_READY) [*2])
    else $error("protected erase started a cycle");
  out_fall_a: assert property ($changed(l1_out_q) |-> $past(fall))
    else $error("output changed off a falling edge");
  latch_need_a: assert property ($rose(eng_q == EN_BUSY) |-> $past(write_enable_latch_q))
    else $error("internal cycle started without latch");

endmodule
`default_nettype wire

/* sfp_pkg.sv */
// How it works
// - Host bits sampled on link clock rise
// - Output bits change on link clock fall
// - Clock idle low or high both accepted
// - Dual reads drive both lanes; DIOR also takes its address on both
// - Reset only right after reset enable
// - Write instructions rejected during power-up hold
// - Write enable latch clear at power-up
// - Program, erase, status write need latch
// - Write enable sets the latch
// - Accepted write-type instructions clear the latch
// - Busy reads one during internal cycle
// - While busy only status reads accepted
// - Busy clears when internal cycle ends
// - Three range bits choose protected region
// - Top/bottom bit anchors protected range
// - Top/bottom changes only when write permitted
// - Granularity bit picks sectors or blocks
// - Complement bit inverts protected region
// - Guard pin combines with lock bits
// - Lock codes: open, pin, power, permanent
package sfp_pkg;

  localparam int unsigned CLK_MHZ  = 100;
  localparam int unsigned T_RST_US = 30;
  localparam int unsigned RST_CYCLES = T_RST_US * CLK_MHZ;
  localparam int unsigned TMR_W    = 24;
  localparam int unsigned ADDR_W   = 24;
  localparam int unsigned CNT_W    = 7;

  // Instruction codes
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_WRSR  = 8'h01;
  localparam logic [7:0] OP_PP    = 8'h02;
  localparam logic [7:0] OP_SE    = 8'h20;
  localparam logic [7:0] OP_BE    = 8'hD8;
  localparam logic [7:0] OP_CE1   = 8'hC7;
  localparam logic [7:0] OP_CE2   = 8'h60;
  localparam logic [7:0] OP_RSTEN = 8'h66;
  localparam logic [7:0] OP_RST   = 8'h99;
  localparam logic [7:0] OP_DOR   = 8'h3B;
  localparam logic [7:0] OP_DIOR  = 8'hBB;

  // Rising-edge counts that mark frame boundaries
  localparam logic [CNT_W-1:0] OPC_BITS   = 7'h08;
  localparam logic [CNT_W-1:0] WRSR_ONE   = 7'h10;
  localparam logic [CNT_W-1:0] WRSR_TWO   = 7'h18;
  localparam logic [CNT_W-1:0] DIOR_ADDR  = 7'h14;
  localparam logic [CNT_W-1:0] DIOR_START = 7'h18;
  localparam logic [CNT_W-1:0] ADDR_END   = 7'h20;
  localparam logic [CNT_W-1:0] PP_MIN     = 7'h28;
  localparam logic [CNT_W-1:0] DOR_START  = 7'h28;

  // Status word one bit positions, status word two positions
  localparam int unsigned SR_BUSY = 0;
  localparam int unsigned SR_LATCH = 1;
  localparam int unsigned SR2_LOCK_HI = 0;
  localparam int unsigned SR2_CMP     = 6;

  localparam logic [1:0] LOCK_OPEN  = 2'h0;
  localparam logic [1:0] LOCK_PIN   = 2'h1;
  localparam logic [1:0] LOCK_POWER = 2'h2;

  // Protection size as log2 of bytes
  localparam logic [4:0] BLK_BASE = 5'h11;
  localparam logic [4:0] SEC_BASE = 5'h0B;
  localparam logic [4:0] SEC_MAX  = 5'h0F;
  localparam logic [4:0] ALL_LOG2 = 5'h18;
  localparam logic [2:0] BP_ALL   = 3'h7;

  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [4:0] SYNC_RST    = 5'h12;

  typedef struct packed {
    logic       cmp;
    logic       lock_hi;
    logic       lock_lo;
    logic       sec;
    logic       tb;
    logic [2:0] bp;
  } sfp_prot_t;

  localparam sfp_prot_t PROT_RST = 8'h00;

  typedef enum logic [1:0] {
    EN_HOLD  = 2'h0,
    EN_READY = 2'h1,
    EN_BUSY  = 2'h3,
    EN_RESET = 2'h2
  } sfp_eng_t;

endpackage

/* sfp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module sfp_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] hold_q;

  generate
    for (genvar i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge sys_clk_in or posedge rst_in)
      begin
        if (rst_in)
        begin
          meta_q[i] <= RST_VAL[i];
          hold_q[i] <= RST_VAL[i];
        end
        else
        begin
          meta_q[i] <= async_in[i];
          hold_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign sync_out = hold_q;

endmodule
`default_nettype wire

/* sfp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sfp_host_model (
  // Timing base
  input  wire logic       sys_clk_in,
  // Lanes as seen on the wire
  input  wire logic       lane_zero_in,
  input  wire logic       lane_one_in,
  // Link drive
  output logic            spi_clk_out,
  output logic            sel_n_out,
  output logic            lane_zero_out,
  output logic            lane_zero_oe_out,
  // Captured read byte
  output logic [7:0]      rd_byte_out,
  output logic            rd_valid_out
);
  logic mode3;

  initial
  begin
    mode3 = 1'b0;
    spi_clk_out = 1'b0;
    sel_n_out = 1'b1;
    lane_zero_out = 1'b0;
    lane_zero_oe_out = 1'b0;
    rd_byte_out = 8'h00;
    rd_valid_out = 1'b0;
  end

  task automatic half();
    repeat (4) @(negedge sys_clk_in);
  endtask

  // Bits change in the low phase; read bits are taken late in the high phase
  task automatic frame(input logic [63:0] tx, input int ntx, input int nrx, input bit dual);
    logic [7:0] rx;
    rx = 8'h00;
    spi_clk_out = mode3;
    half();
    sel_n_out = 1'b0;
    lane_zero_oe_out = 1'b1;
    half();
    for (int k = 0; k < ntx + nrx; k++)
    begin
      spi_clk_out = 1'b0;
      if (k < ntx)
        lane_zero_out = tx[ntx-1-k];
      else
        lane_zero_oe_out = 1'b0;
      half();
      spi_clk_out = 1'b1;
      half();
      if (k >= ntx)
        rx = dual ? {rx[5:0], lane_one_in, lane_zero_in} : {rx[6:0], lane_one_in};
    end
    if (!mode3)
      spi_clk_out = 1'b0;
    half();
    sel_n_out = 1'b1;
    lane_zero_oe_out = 1'b0;
    if (nrx > 0)
    begin
      rd_byte_out = rx;
      rd_valid_out = 1'b1;
      @(negedge sys_clk_in);
      rd_valid_out = 1'b0;
    end
    half();
  endtask
endmodule
`default_nettype wire

/* serial_flash_status_protect_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_flash_status_protect_tb
  import sfp_pkg::*;
();
  logic        sys_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        write_guard_n_in = 1'b1;
  logic        spi_clk, sel_n, h_val, h_oe, rv;
  logic        l0_out, l0_oe, l1_out, l1_oe;
  wire logic   l0_w, l1_w;
  logic [7:0]  rb, status_word;
  logic [23:0] exp_q[$];
  logic [23:0] nt;
  logic [23:0] pa, ua;
  logic [7:0]  s, lo;
  logic [2:0]  bp;
  logic        tb;
  int          n_mismatch = 0;
  int          samples_checked = 0;

  always #5 sys_clk_in = ~sys_clk_in;

  // Released lanes toggle so a stale level cannot pass for data
  assign l0_w = l0_oe ? l0_out : (h_oe ? h_val : ~spi_clk);
  assign l1_w = l1_oe ? l1_out : ~spi_clk;

  sfp_front #(.PUW_US(1), .PROG_CYCLES(400), .ERASE_CYCLES(400), .WRSR_CYCLES(400)) i_sfp_front (
    .sys_clk_in            (sys_clk_in),
    .rst_in                (rst_in),
    .spi_clk_in            (spi_clk),
    .sel_n_in              (sel_n),
    .write_guard_n_in      (write_guard_n_in),
    .dual_lane_zero_in     (l0_w),
    .dual_lane_zero_out    (l0_out),
    .dual_lane_zero_oe_out (l0_oe),
    .dual_lane_one_in      (l1_w),
    .dual_lane_one_out     (l1_out),
    .dual_lane_one_oe_out  (l1_oe),
    .status_word_one_out   (status_word)
  );

  sfp_host_model i_sfp_host_model (
    .sys_clk_in       (sys_clk_in),
    .lane_zero_in     (l0_w),
    .lane_one_in      (l1_w),
    .spi_clk_out      (spi_clk),
    .sel_n_out        (sel_n),
    .lane_zero_out    (h_val),
    .lane_zero_oe_out (h_oe),
    .rd_byte_out      (rb),
    .rd_valid_out     (rv)
  );

  task automatic fr(input logic [63:0] tx, input int n);
    i_sfp_host_model.frame(tx, n, 0, 1'b0);
  endtask

  task automatic op(input logic [7:0] c);
    fr({56'h0, c}, 8);
  endtask

  task automatic rd(input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back({e, m, m});
    i_sfp_host_model.frame({56'h0, OP_RDSR1}, 8, 8, 1'b0);
  endtask

  task automatic idle();
    repeat (450) @(negedge sys_clk_in);
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Each captured byte is judged against the oldest expectation under its mask
  always @(posedge sys_clk_in)
  begin
    if (rv === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        n_mismatch++;
        $display("CHECK FAILED %0t unexpected read byte", $time);
      end
      else
      begin
        nt = exp_q.pop_front();
        samples_checked++;
        if ((rb & nt[15:8]) !== (nt[23:16] & nt[15:8]))
        begin
          n_mismatch++;
          $display("CHECK FAILED %0t read %h expected %h mask %h", $time, rb, nt[23:16], nt[15:8]);
        end
        if ((status_word & nt[7:0]) !== (nt[23:16] & nt[7:0]))
        begin
          n_mismatch++;
          $display("CHECK FAILED %0t status word %h expected %h", $time, status_word, nt[23:16]);
        end
      end
    end
  end

  initial
  begin
    repeat (60000) @(posedge sys_clk_in);
    n_mismatch++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    report_and_stop();
  end

  initial
  begin
    void'($urandom(92621));
    tb = 1'($urandom % 2);
    bp = 3'(1 + $urandom % 6);
    lo = 8'($urandom);
    pa = tb ? {16'h0000, lo} : {16'hFFFF, lo};
    ua = tb ? {16'hFFFF, lo} : {16'h0000, lo};
    s = {2'b00, tb, bp, 2'b00};
    repeat (4) @(negedge sys_clk_in);
    rst_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    op(OP_WREN);
    rd(8'h00, 8'hFF);
    op(OP_WREN);
    rd(8'h02, 8'hFF);
    op(OP_WRDI);
    rd(8'h00, 8'h03);
    op(OP_WREN);
    fr({48'h0, OP_WRSR, s | 8'h80}, 16);
    rd(8'h01, 8'h03);
    op(OP_WREN);
    rd(8'h01, 8'h03);
    idle();
    rd(s | 8'h80, 8'hFF);
    write_guard_n_in = 1'b0;
    op(OP_WREN);
    fr({48'h0, OP_WRSR, 8'h00}, 16);
    rd(s | 8'h82, 8'hFF);
    write_guard_n_in = 1'b1;
    fr({48'h0, OP_WRSR, s}, 16);
    idle();
    rd(s, 8'hFF);
    op(OP_WREN);
    fr({24'h0, OP_PP, pa, lo}, 40);
    rd(8'h02, 8'h03);
    fr({32'h0, OP_SE, pa}, 32);
    rd(8'h02, 8'h03);
    fr({24'h0, OP_PP, ua, lo}, 40);
    rd(8'h01, 8'h03);
    idle();
    rd(8'h00, 8'h03);
    fr({24'h0, OP_PP, ua, lo}, 40);
    rd(8'h00, 8'h03);
    i_sfp_host_model.mode3 = 1'b1;
    op(OP_WREN);
    fr({40'h0, OP_WRSR, s, 8'h40}, 24);
    idle();
    exp_q.push_back({8'h40, 8'hFF, 8'h00});
    i_sfp_host_model.frame({56'h0, OP_RDSR2}, 8, 8, 1'b0);
    op(OP_WREN);
    fr({24'h0, OP_PP, ua, lo}, 40);
    rd(8'h02, 8'h03);
    op(OP_CE1);
    op(OP_CE2);
    fr({32'h0, OP_BE, ua}, 32);
    rd(8'h02, 8'h03);
    fr({24'h0, OP_PP, pa, lo}, 40);
    rd(8'h01, 8'h03);
    idle();
    exp_q.push_back(24'hFFFF00);
    i_sfp_host_model.frame({24'h0, OP_DOR, ua, 8'h00}, 40, 4, 1'b1);
    exp_q.push_back(24'hFFFF00);
    i_sfp_host_model.frame({40'h0, OP_DIOR, 16'h0000}, 24, 4, 1'b1);
    i_sfp_host_model.mode3 = 1'b0;
    op(OP_RSTEN);
    op(OP_WREN);
    op(OP_RST);
    rd(8'h02, 8'h03);
    op(OP_RSTEN);
    op(OP_RST);
    rd(8'h01, 8'h03);
    repeat (3100) @(negedge sys_clk_in);
    rd(s, 8'hFF);
    op(OP_WREN);
    fr({40'h0, OP_WRSR, s, 8'h01}, 24);
    idle();
    op(OP_WREN);
    fr({48'h0, OP_WRSR, 8'h00}, 16);
    rd(s | 8'h02, 8'hFF);
    exp_q.push_back({8'h01, 8'hFF, 8'h00});
    i_sfp_host_model.frame({56'h0, OP_RDSR2}, 8, 8, 1'b0);
    rst_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    rst_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    rd(8'h00, 8'hFF);
    exp_q.push_back({8'h00, 8'hFF, 8'h00});
    i_sfp_host_model.frame({56'h0, OP_RDSR2}, 8, 8, 1'b0);
    repeat (5) @(negedge sys_clk_in);
    report_and_stop();
  end
endmodule
`default_nettype wire
